/* shared/fblp_pkg.sv */
// package: constants and types of the flash block lock and protection logic
package fblp_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NBLK = 8;
  localparam int BLK_W = 3;
  localparam int NPART = 4;
  localparam int PART_W = 2;
  localparam int PRW_W = 3;
  localparam logic [PART_W-1:0] PARAM_PART = 2'h0;
  localparam logic [PRW_W-1:0] PR_USER_FIRST = 3'h4;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_LOCKS = 8'h08;
  localparam logic [7:0] ADR_WSM = 8'h0C;
  localparam logic [7:0] ADR_PR_WDATA = 8'h10;
  localparam logic [7:0] ADR_PR_READ = 8'h14;
  localparam logic [7:0] ADR_ACCESS = 8'h18;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CMD_BLK_LSB = 8;
  localparam int CMD_PART_LSB = 12;
  localparam int CMD_PRW_LSB = 16;
  localparam int ACC_PR_BIT = 4;
  localparam int PR_GRANT_BIT = 16;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESUME = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_UNLOCK = 8'h02;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
  localparam logic [7:0] CMD_PR_PROGRAM = 8'hC0;
  localparam logic [7:0] CMD_PR_LOCK = 8'hC1;

  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int SR_LERR = 1;
  localparam int SR_PSUSP = 2;
  localparam int SR_VERR = 3;
  localparam int SR_PERR = 4;
  localparam int SR_ESUSP = 6;
  localparam int SR_READY = 7;
  localparam int SR_DENIED = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic LOCK_RST = 1'b1;
  localparam logic LDOWN_RST = 1'b0;
  localparam logic [2:0] PIN_RST = 3'h1; // wp_n high, supply low, pin reset active
  localparam logic [63:0] PR_USER_RST = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [63:0] PR_UID = 64'h0123456789ABCDEF; // arbitrary value

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int PROG_NS = 100;
  localparam int ERASE_NS = 400;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'((PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ERASE_CYC = CNT_W'((ERASE_NS + CLK_NS - 1) / CLK_NS);

  // read mode of one partition
  typedef enum logic [1:0] {RM_ARRAY, RM_STATUS, RM_ID, RM_QUERY} fblp_rmode_e;

endpackage

/* rtl/fblp_top.sv */
// module: flash block lock, suspend/resume and protection register logic behind Wishbone
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fblp_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins
  input wire logic write_protect_n_i,
  input wire logic supply_ok_i,
  input wire logic pin_reset_n_i,
  // array write and erase strobes and their block
  output logic array_write_o,
  output logic array_erase_o,
  output logic [2:0] array_blk_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_q;
  assign pin_raw = {pin_reset_n_i, supply_ok_i, write_protect_n_i};

  // a pin only changes once two settled samples agree, filtering single glitches
  for (genvar i = 0; i < 3; i++)
  begin : g_pin
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        pin_s1[i] <= fblp_pkg::PIN_RST[i];
        pin_s2[i] <= fblp_pkg::PIN_RST[i];
        pin_s3[i] <= fblp_pkg::PIN_RST[i];
        pin_q[i] <= fblp_pkg::PIN_RST[i];
      end
      else
      begin
        pin_s1[i] <= pin_raw[i];
        pin_s2[i] <= pin_s1[i];
        pin_s3[i] <= pin_s2[i];
        if (pin_s2[i] == pin_s3[i])
          pin_q[i] <= pin_s3[i];
      end
    end
  end

  logic wp_low;
  logic supply_ok;
  logic hold;
  assign wp_low = ~pin_q[0];
  assign supply_ok = pin_q[1];
  assign hold = rst_i | ~pin_q[2];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic cmd;
  logic [7:0] code;
  logic [2:0] c_blk;
  logic [1:0] c_part;
  logic [2:0] c_prw;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0] & ~hold;
  assign rd = req & ~wb_we_i;
  assign cmd = wr && (wb_adr_i == fblp_pkg::ADR_CMD);
  assign code = wb_dat_i[7:0];
  assign c_blk = wb_dat_i[fblp_pkg::CMD_BLK_LSB +: 3];
  assign c_part = wb_dat_i[fblp_pkg::CMD_PART_LSB +: 2];
  assign c_prw = wb_dat_i[fblp_pkg::CMD_PRW_LSB +: 3];

  // ----------------------------------------------------------------
  // operation state
  // ----------------------------------------------------------------
  logic erase_act;
  logic erase_susp;
  logic prog_act;
  logic prog_susp;
  logic pr_act;
  logic [2:0] erase_blk;
  logic [2:0] prog_blk;
  logic [2:0] pr_word;
  logic [7:0] erase_cnt;
  logic [7:0] prog_cnt;
  logic [fblp_pkg::NBLK-1:0] lock;
  logic [fblp_pkg::NBLK-1:0] ldown;
  logic prog_run;
  logic erase_run;
  logic ready;
  logic busy_any;
  logic [1:0] busy_part;
  logic prot;
  logic prog_try;
  logic erase_try;
  logic start_ok;
  logic lk_cmd;
  logic lk_ok;
  logic resume;
  assign prog_run = prog_act & ~prog_susp;
  assign erase_run = erase_act & ~erase_susp;
  assign ready = ~(prog_run | erase_run | pr_act);
  assign busy_any = prog_run | erase_run | pr_act;
  assign busy_part = pr_act ? fblp_pkg::PARAM_PART :
                     prog_run ? prog_blk[2:1] : erase_blk[2:1];
  // protection is the lock bit plus a lock-down held by write protect
  assign prot = lock[c_blk] | (ldown[c_blk] & wp_low);
  assign prog_try = cmd && code == fblp_pkg::CMD_PROGRAM && !prog_act && !pr_act &&
                    (!erase_act || (erase_susp && c_blk != erase_blk));
  assign erase_try = cmd && code == fblp_pkg::CMD_ERASE && !erase_act && !prog_act && !pr_act;
  assign start_ok = !prot && supply_ok;
  assign lk_cmd = cmd && (code == fblp_pkg::CMD_LOCK || code == fblp_pkg::CMD_UNLOCK ||
                          code == fblp_pkg::CMD_LOCKDOWN);
  // a suspended program keeps prog_act high, so it shuts out locking too
  assign lk_ok = !prog_act && !pr_act && (!erase_act || erase_susp);
  assign resume = cmd && code == fblp_pkg::CMD_RESUME;

  // program path: array program, nested program in erase suspend, suspend and resume
  always_ff @(posedge clk_i)
  begin
    if (hold)
    begin
      prog_act <= 1'b0;
      prog_susp <= 1'b0;
      prog_blk <= 3'h0;
      prog_cnt <= 8'h00;
    end
    else if (prog_try && start_ok)
    begin
      prog_act <= 1'b1;
      prog_blk <= c_blk;
      prog_cnt <= fblp_pkg::PROG_CYC;
    end
    else if (cmd && code == fblp_pkg::CMD_SUSPEND && prog_run && prog_cnt != 8'h01)
      prog_susp <= 1'b1; // the committing cycle cannot be suspended, its strobe is out
    else if (resume && prog_susp)
      prog_susp <= 1'b0;
    else if (prog_run)
    begin
      prog_cnt <= prog_cnt - 8'h01;
      if (prog_cnt == 8'h01)
        prog_act <= 1'b0;
    end
  end

  // erase path: a program suspend is served first, then the erase resumes
  always_ff @(posedge clk_i)
  begin
    if (hold)
    begin
      erase_act <= 1'b0;
      erase_susp <= 1'b0;
      erase_blk <= 3'h0;
      erase_cnt <= 8'h00;
    end
    else if (erase_try && start_ok)
    begin
      erase_act <= 1'b1;
      erase_blk <= c_blk;
      erase_cnt <= fblp_pkg::ERASE_CYC;
    end
    else if (cmd && code == fblp_pkg::CMD_SUSPEND && erase_run && !prog_act &&
             erase_cnt != 8'h01)
      erase_susp <= 1'b1;
    else if (resume && erase_susp && !prog_act)
      erase_susp <= 1'b0;
    else if (erase_run)
    begin
      // lock bits are not consulted again, so a block locked in suspend still erases
      erase_cnt <= erase_cnt - 8'h01;
      if (erase_cnt == 8'h01)
        erase_act <= 1'b0;
    end
  end

  // array strobes mark the moment an operation commits to the array
  always_ff @(posedge clk_i)
  begin
    if (hold)
    begin
      array_write_o <= 1'b0;
      array_erase_o <= 1'b0;
      array_blk_o <= 3'h0;
    end
    else
    begin
      array_write_o <= prog_run && prog_cnt == 8'h01;
      array_erase_o <= erase_run && erase_cnt == 8'h01 && !(prog_run && prog_cnt == 8'h01);
      array_blk_o <= (prog_run && prog_cnt == 8'h01) ? prog_blk : erase_blk;
    end
  end

  // ----------------------------------------------------------------
  // block lock bits
  // ----------------------------------------------------------------
  for (genvar b = 0; b < fblp_pkg::NBLK; b++)
  begin : g_blk
    always_ff @(posedge clk_i)
    begin
      if (hold)
      begin
        lock[b] <= fblp_pkg::LOCK_RST;
        ldown[b] <= fblp_pkg::LDOWN_RST;
      end
      else if (wp_low && ldown[b])
        lock[b] <= 1'b1;
      else if (lk_cmd && lk_ok && c_blk == 3'(b))
      begin
        if (code == fblp_pkg::CMD_LOCK)
          lock[b] <= 1'b1;
        else if (code == fblp_pkg::CMD_UNLOCK)
          lock[b] <= 1'b0;
        else
        begin
          lock[b] <= 1'b1;
          ldown[b] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read modes of the partitions
  // ----------------------------------------------------------------
  fblp_pkg::fblp_rmode_e [fblp_pkg::NPART-1:0] rmode;

  // suspend and resume leave the modes alone, so a mode picked in suspend persists
  always_ff @(posedge clk_i)
  begin
    if (hold)
      rmode <= '{default: fblp_pkg::RM_ARRAY};
    else if (cmd)
    begin
      if (code == fblp_pkg::CMD_READ_ARRAY)
        rmode[c_part] <= fblp_pkg::RM_ARRAY;
      else if (code == fblp_pkg::CMD_READ_ID)
        rmode[c_part] <= fblp_pkg::RM_ID;
      else if (code == fblp_pkg::CMD_READ_QUERY)
        rmode[c_part] <= fblp_pkg::RM_QUERY;
      else if (code == fblp_pkg::CMD_READ_STATUS || code == fblp_pkg::CMD_PROGRAM ||
               code == fblp_pkg::CMD_ERASE || code == fblp_pkg::CMD_PR_PROGRAM)
        rmode[c_part] <= fblp_pkg::RM_STATUS;
    end
  end

  // ----------------------------------------------------------------
  // protection register
  // ----------------------------------------------------------------
  logic [63:0] pr_user;
  logic pr_ulock;
  logic [15:0] pr_wdata;
  logic [2:0] pr_sel_word;
  logic [1:0] pr_sel_part;
  logic [1:0] acc_part;
  logic acc_pr;
  logic [7:0] pr_cnt;
  logic pr_try;
  logic pr_bad;
  assign pr_try = cmd && code == fblp_pkg::CMD_PR_PROGRAM && !busy_any && !erase_act &&
                  !prog_act;
  assign pr_bad = c_prw < fblp_pkg::PR_USER_FIRST || pr_ulock || !supply_ok;

  // only the upper four words can change; the lock is one-way until power is lost
  always_ff @(posedge clk_i)
  begin
    if (hold)
    begin
      pr_act <= 1'b0;
      pr_word <= 3'h0;
      pr_cnt <= 8'h00;
    end
    else if (pr_try && !pr_bad)
    begin
      pr_act <= 1'b1;
      pr_word <= c_prw;
      pr_cnt <= fblp_pkg::PROG_CYC;
    end
    else if (pr_act)
    begin
      pr_cnt <= pr_cnt - 8'h01;
      if (pr_cnt == 8'h01)
        pr_act <= 1'b0;
    end
  end

  // user half storage; bits only program toward zero as flash does
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pr_user <= fblp_pkg::PR_USER_RST;
      pr_ulock <= 1'b0;
    end
    else if (pr_act && pr_cnt == 8'h01)
      pr_user[16*(pr_word[1:0]) +: 16] <= pr_user[16*(pr_word[1:0]) +: 16] & pr_wdata;
    else if (cmd && code == fblp_pkg::CMD_PR_LOCK && !busy_any)
      pr_ulock <= 1'b1;
  end

  // selection registers written by software
  always_ff @(posedge clk_i)
  begin
    if (hold)
    begin
      pr_wdata <= 16'hFFFF;
      pr_sel_word <= 3'h0;
      pr_sel_part <= 2'h0;
      acc_part <= 2'h0;
      acc_pr <= 1'b0;
    end
    else if (wr && wb_adr_i == fblp_pkg::ADR_PR_WDATA)
      pr_wdata <= wb_dat_i[15:0];
    else if (wr && wb_adr_i == fblp_pkg::ADR_PR_READ)
    begin
      pr_sel_word <= wb_dat_i[2:0];
      pr_sel_part <= wb_dat_i[5:4];
    end
    else if (wr && wb_adr_i == fblp_pkg::ADR_ACCESS)
    begin
      acc_part <= wb_dat_i[1:0];
      acc_pr <= wb_dat_i[fblp_pkg::ACC_PR_BIT];
    end
  end

  // may the protection register be read through partition p
  function automatic logic pr_read_ok(input logic [1:0] p);
    if (pr_act || (busy_any && busy_part == fblp_pkg::PARAM_PART))
      return 1'b0;
    if (busy_any)
      return p != busy_part && p != fblp_pkg::PARAM_PART;
    return 1'b1;
  endfunction

  // may array data be read in partition p
  function automatic logic arr_read_ok(input logic [1:0] p);
    if (busy_any)
      return p != busy_part;
    return 1'b1;
  endfunction

  logic pr_grant;
  logic [15:0] pr_word_val;
  assign pr_grant = pr_read_ok(pr_sel_part);
  assign pr_word_val = pr_sel_word[2] ? pr_user[16*(pr_sel_word[1:0]) +: 16] :
                       fblp_pkg::PR_UID[16*(pr_sel_word[1:0]) +: 16];

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  logic lerr;
  logic verr;
  logic perr;
  logic denied;
  logic clr;
  logic set_l;
  logic set_v;
  logic set_p;
  logic set_d;
  assign clr = cmd && code == fblp_pkg::CMD_CLR_STATUS;
  assign set_l = ((prog_try || erase_try) && prot) || (pr_try && pr_ulock);
  assign set_v = (prog_try || erase_try) && !supply_ok;
  assign set_p = pr_try && pr_bad;
  assign set_d = rd && wb_adr_i == fblp_pkg::ADR_PR_READ && !pr_grant;

  // a flag set in the clearing cycle survives the clear
  always_ff @(posedge clk_i)
  begin
    if (hold)
    begin
      lerr <= 1'b0;
      verr <= 1'b0;
      perr <= 1'b0;
      denied <= 1'b0;
    end
    else
    begin
      lerr <= (lerr & ~clr) | set_l;
      verr <= (verr & ~clr) | set_v;
      perr <= (perr & ~clr) | set_p;
      denied <= (denied & ~clr) | set_d;
    end
  end

  // ----------------------------------------------------------------
  // read mux and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] next_dat;
  always_comb
  begin
    next_dat = 32'h00000000;
    if (!hold)
    begin
      unique case (wb_adr_i)
        fblp_pkg::ADR_STATUS:
        begin
          next_dat[fblp_pkg::SR_READY] = ready;
          next_dat[fblp_pkg::SR_ESUSP] = erase_susp;
          next_dat[fblp_pkg::SR_PERR] = perr;
          next_dat[fblp_pkg::SR_VERR] = verr;
          next_dat[fblp_pkg::SR_PSUSP] = prog_susp;
          next_dat[fblp_pkg::SR_LERR] = lerr;
          next_dat[fblp_pkg::SR_DENIED] = denied;
        end
        fblp_pkg::ADR_LOCKS:
          for (int b = 0; b < fblp_pkg::NBLK; b++)
            next_dat[2*b +: 2] = {ldown[b], lock[b]};
        fblp_pkg::ADR_WSM:
          next_dat = {8'h00, rmode, 5'h00, prog_blk, 1'b0, erase_blk,
                      1'b0, pr_act, prog_act, erase_act};
        fblp_pkg::ADR_PR_WDATA:
          next_dat = {16'h0000, pr_wdata};
        fblp_pkg::ADR_PR_READ:
          next_dat = {15'h0000, pr_grant, pr_grant ? pr_word_val : 16'h0000};
        fblp_pkg::ADR_ACCESS:
          next_dat = {31'h00000000, acc_pr ? pr_read_ok(acc_part) : arr_read_ok(acc_part)};
        default:
          next_dat = 32'h00000000;
      endcase
    end
  end

  // every access, mapped or not, is answered one cycle after it is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req;
      if (rd)
        wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_prog_resume;
    resume && prog_susp;
  endsequence

  sequence s_prog_cleared;
    !prog_susp && !ready;
  endsequence

  a_reset_locks: assert property (@(posedge clk_i) rst_i |=> lock == '1 && ldown == '0)
    else $error("blocks not locked after reset");
  a_pin_reset_locks: assert property (@(posedge clk_i) disable iff (rst_i)
    !pin_q[2] |=> lock == '1 && ldown == '0 && (wb_dat_o == 32'h0 || !$past(rd)))
    else $error("pin reset left a block unlocked");
  a_resume_prog: assert property (@(posedge clk_i) disable iff (hold)
    s_prog_resume |=> s_prog_cleared)
    else $error("program resume did not restart");
  a_resume_waits: assert property (@(posedge clk_i) disable iff (hold)
    resume && erase_susp && prog_act |=> erase_susp)
    else $error("erase resumed over a nested program");
  a_locked_refused: assert property (@(posedge clk_i) disable iff (hold)
    prog_try && prot |=> !prog_act && lerr)
    else $error("program accepted on protected block");
  a_ldown_frozen: assert property (@(posedge clk_i) disable iff (hold)
    lk_cmd && wp_low && ldown[c_blk] |=> ldown == $past(ldown) && lock[$past(c_blk)])
    else $error("locked-down block changed under write protect");
  a_wp_relock: assert property (@(posedge clk_i) disable iff (hold)
    wp_low ##1 wp_low |-> (ldown & ~lock) == '0)
    else $error("locked-down block stayed unlocked");
  a_psusp_nolock: assert property (@(posedge clk_i) disable iff (hold)
    lk_cmd && prog_susp && !wp_low |=> lock == $past(lock) && ldown == $past(ldown))
    else $error("lock changed in program suspend");
  a_modes_kept: assert property (@(posedge clk_i) disable iff (hold)
    resume |=> rmode == $past(rmode))
    else $error("read mode lost at resume");
  a_supply_refuse: assert property (@(posedge clk_i) disable iff (hold)
    erase_try && !supply_ok |=> !erase_act && verr)
    else $error("erase started with low supply");
  a_param_pr_closed: assert property (@(posedge clk_i) disable iff (hold)
    rd && wb_adr_i == fblp_pkg::ADR_PR_READ && pr_act |=> !wb_dat_o[16] ##1 denied)
    else $error("protection register read during its programming");
  a_erase_done: assert property (@(posedge clk_i) disable iff (hold)
    erase_run && erase_cnt == 8'h01 && !prog_act |=> !erase_act && array_erase_o)
    else $error("erase did not complete");

endmodule

`default_nettype wire

/* dv/fblp_host.sv */
// host model: classic wishbone master that issues flash commands
`timescale 1ns/1ps
`default_nettype none
module fblp_host (
  // clock
  input wire logic clk_i,
  // bus answer
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  // bus request
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  // idle bus at time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h00000000;
  end
  // one cycle, held until ack is sampled; the wait is bounded so a dead slave cannot hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = (wb_ack_i === 1'b1);
    end
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~d; // released data does not keep its value
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// testbench: block locks and lock-down under write protect, erase and program suspend, protection register and pins
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n = 1'b1;
  logic sup = 1'b1;
  logic prn = 1'b1;
  logic cyc, stb, we, ack, aw, ae;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] blk;
  int error_cnt = 0;
  int checked = 0;
  int writes = 0;
  always #2.5 clk_i = ~clk_i;
  // committed programs seen at the array side
  always @(posedge clk_i) if (aw === 1'b1) writes++;
  fblp_host i_fblp_host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  fblp_top i_fblp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .write_protect_n_i(wp_n), .supply_ok_i(sup), .pin_reset_n_i(prn),
    .array_write_o(aw), .array_erase_o(ae), .array_blk_o(blk));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    i_fblp_host.bus(w, a, d, q, ok);
    if (!ok)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t no ack", $time);
      conclude();
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [2:0] b);
    op(1'b1, fblp_pkg::ADR_CMD, {21'h0, b, c});
  endtask
  // reset held five cycles, then room for the pin synchronisers
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic set_wp(input logic v);
    wp_n <= v;
    repeat (8) @(posedge clk_i);
  endtask
  // a locked block refuses program and flags lock error
  task automatic t_locked();
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005555);
    cmd(fblp_pkg::CMD_PROGRAM, 3'h1);
    repeat (30) @(posedge clk_i);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'h2, 32'h2);
    chk(writes, 0);
    $display("test locked done");
  endtask
  // unlock then program reaches the array
  task automatic t_unlock();
    int n;
    cmd(fblp_pkg::CMD_CLR_STATUS, 3'h0);
    cmd(fblp_pkg::CMD_UNLOCK, 3'h1);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005551);
    cmd(fblp_pkg::CMD_PROGRAM, 3'h1);
    for (n = 0; n < 60 && writes == 0; n++) @(posedge clk_i);
    chk(writes, 1);
    $display("test unlock done");
  endtask
  // lock-down under both levels of write protect, then reset
  task automatic t_lockdown();
    cmd(fblp_pkg::CMD_LOCKDOWN, 3'h2);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005571);
    set_wp(1'b0);
    cmd(fblp_pkg::CMD_UNLOCK, 3'h2);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005571);
    set_wp(1'b1);
    cmd(fblp_pkg::CMD_UNLOCK, 3'h2);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005561);
    set_wp(1'b0);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005571);
    do_reset();
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005555);
    $display("test lockdown done");
  endtask
  // erase suspend: lock changes, a nested program with its own suspend, then resumes
  task automatic t_suspend();
    int n;
    set_wp(1'b1);
    cmd(fblp_pkg::CMD_UNLOCK, 3'h4);
    cmd(fblp_pkg::CMD_ERASE, 3'h4);
    cmd(fblp_pkg::CMD_SUSPEND, 3'h0);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'hC4, 32'hC0);
    cmd(fblp_pkg::CMD_LOCKDOWN, 3'h4);
    cmd(fblp_pkg::CMD_UNLOCK, 3'h0);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005754);
    cmd(fblp_pkg::CMD_PROGRAM, 3'h0);
    cmd(fblp_pkg::CMD_SUSPEND, 3'h0);
    cmd(fblp_pkg::CMD_LOCK, 3'h0);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'hC4, 32'hC4);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005754);
    cmd(fblp_pkg::CMD_RESUME, 3'h0);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'hC4, 32'h40);
    for (n = 0; n < 60 && writes < 2; n++) @(posedge clk_i);
    chk(writes, 2);
    op(1'b1, fblp_pkg::ADR_CMD, 32'h00001090);
    cmd(fblp_pkg::CMD_RESUME, 3'h0);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'hC4, 32'h00);
    op(1'b0, fblp_pkg::ADR_WSM, 32'h0);
    chk(q, 32'h00090041);
    op(1'b1, fblp_pkg::ADR_CMD, 32'h00001070);
    op(1'b0, fblp_pkg::ADR_WSM, 32'h0);
    chk(q, 32'h00050041);
    for (n = 0; n < 200 && ae !== 1'b1; n++) @(posedge clk_i);
    chk({ae, blk}, 4'hC);
    $display("test suspend done");
  endtask
  // user half of the protection register, refused while it programs
  task automatic t_prot();
    op(1'b1, fblp_pkg::ADR_PR_WDATA, 32'h0000A5A5);
    op(1'b1, fblp_pkg::ADR_PR_READ, 32'h00000004);
    op(1'b1, fblp_pkg::ADR_CMD, 32'h000400C0);
    op(1'b0, fblp_pkg::ADR_PR_READ, 32'h0);
    chk(q, 32'h0);
    repeat (30) @(posedge clk_i);
    op(1'b0, fblp_pkg::ADR_PR_READ, 32'h0);
    chk(q, 32'h0001A5A5);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'h100, 32'h100);
    $display("test prot done");
  endtask
  // low supply refuses erase; the reset pin blanks the bus and relocks every block
  task automatic t_pins();
    sup <= 1'b0;
    repeat (8) @(posedge clk_i);
    cmd(fblp_pkg::CMD_UNLOCK, 3'h5);
    cmd(fblp_pkg::CMD_ERASE, 3'h5);
    op(1'b0, fblp_pkg::ADR_STATUS, 32'h0);
    chk(q & 32'h0A, 32'h08);
    op(1'b0, fblp_pkg::ADR_WSM, 32'h0);
    chk(q & 32'h1, 32'h0);
    sup <= 1'b1;
    prn <= 1'b0;
    repeat (8) @(posedge clk_i);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h0);
    prn <= 1'b1;
    repeat (8) @(posedge clk_i);
    op(1'b0, fblp_pkg::ADR_LOCKS, 32'h0);
    chk(q, 32'h00005555);
    $display("test pins done");
  endtask
  initial
  begin
    do_reset();
    t_locked();
    t_unlock();
    t_lockdown();
    t_suspend();
    t_prot();
    t_pins();
    conclude();
  end
endmodule
`default_nettype wire
